// ---- async_rx_pkg.sv ----
// Types shared by the serial receiver
package async_rx_pkg;

    // Receiver sequencing
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;

    // Software-visible configuration bits
    typedef struct packed {
        logic port_enable;
        logic ninth_enable;
        logic cont_receive;
        logic addr_detect;
        logic clocked_mode;
        logic high_speed;
        logic wide_divisor;
        logic wake_enable;
        logic receive_ie;
        logic global_ie;
        logic periph_ie;
        logic [7:0] div_high;
        logic [7:0] div_low;
        logic [7:0] tx_buffer;
    } config_t;

    // Receiver status as software sees it
    typedef struct packed {
        logic [7:0] rx_buffer;
        logic ninth_data;
        logic framing_err;
        logic overrun_err;
        logic receive_flag;
    } status_t;

    // Whole state of the receiver block
    typedef struct packed {
        logic bus_wait;
        logic [31:0] read_data;
        logic irq;
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        rx_state_t fsm;
        logic [1:0] prescale;
        logic [15:0] divider;
        logic [3:0] tick;
        logic [3:0] bit_num;
        logic [8:0] shifter;
        logic wake_seen;
        config_t cfg;
        status_t sts;
    } state_t;

endpackage

// ---- async_rx_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ASYNC_RX_REGS_SVH
`define ASYNC_RX_REGS_SVH

// Register word indices; byte address is four times the index
`define OFS_PERIPH_FLAGS 8'h0C
`define OFS_BAUD_CONTROL 8'h11
`define OFS_BAUD_DIV_HIGH 8'h12
`define OFS_BAUD_DIV_LOW 8'h13
`define OFS_RECEIVE_BUFFER 8'h14
`define OFS_TRANSMIT_BUFFER 8'h15
`define OFS_TRANSMIT_STATUS 8'h16
`define OFS_RECEIVE_STATUS 8'h17
`define OFS_PERIPH_ENABLES 8'h8C
`define OFS_INTERRUPT_CONTROL 8'h0B

// Field positions
`define BIT_RECEIVE_FLAG 5
`define BIT_RECEIVE_IE 5
`define BIT_RECEIVE_IDLE 6
`define BIT_WIDE_DIVISOR 3
`define BIT_WAKE_ENABLE 1
`define BIT_CLOCKED_MODE 4
`define BIT_HIGH_SPEED 2
`define BIT_TX_SHIFT_EMPTY 1
`define BIT_PORT_ENABLE 7
`define BIT_NINTH_ENABLE 6
`define BIT_CONT_RECEIVE 4
`define BIT_ADDR_DETECT 3
`define BIT_FRAMING_ERR 2
`define BIT_OVERRUN_ERR 1
`define BIT_NINTH_DATA 0
`define BIT_GLOBAL_IE 7
`define BIT_PERIPH_IE 6

// Reset values
`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000
`define RST_READ 32'h0000_0000

// Oversampling: sixteen ticks per bit, data sampled mid-bit
`define OVERSAMPLE_LAST 4'hF
`define SAMPLE_POINT 4'h7
`define SLOW_PRESCALE_LAST 2'h3
`define BITS_EIGHT 4'h8
`define BITS_NINE 4'h9

`endif

// ---- async_serial_receiver_wake.sv ----
// Asynchronous serial receiver with address detect and wake-on-break
// Summary of operation
// - Sixteen-times oversampled front end recovers data
// - Main shifter advances once per bit
// - Characters accepted only with continuous receive
// - Complete character sets flag; interrupt if enabled
// - Status shows ninth bit, framing, overrun
// - Received byte read through receive buffer
// - Clearing continuous receive clears error flags
// - Interrupt also needs global and peripheral enables
// - Address detect needs ninth bit and receive
// - Address detect off passes every character
// - Wake enable arms detection without baud clock
// - First falling edge while armed sets flag
// - Following rising edge clears wake enable
// - Unimplemented register bits read as zero
// - Frame: start, eight or nine data, stop
// - Data taken least significant bit first
// - Reading receive buffer clears receive flag
`timescale 1ns/1ns
`default_nettype none
`include "async_rx_regs.svh"

module async_serial_receiver_wake
    import async_rx_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Avalon-MM slave, word addressed
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Serial receive line from the remote sender
    input wire logic RECEIVE_LINE,
    // Receive interrupt request to the processor
    output logic RX_IRQ
);

    state_t st_q;
    state_t st_d;

    logic req;
    logic take;
    logic wr_lo;
    logic rx_enabled;
    logic tick_en;
    logic last_pre;
    logic bit_end;
    logic mid_bit;
    logic fall;
    logic rise;
    logic accept;
    logic [15:0] div_limit;
    logic [7:0] got_byte;
    logic got_ninth;
    logic [7:0] rd_byte;
    logic rd_buffer;
    logic rd_answer;
    logic port_ready;
    logic [3:0] frame_bits;
    logic wake_fall;
    logic wake_rise;
    logic overrun_hit;

    // Bus request handshake terms
    assign req = AVS_READ | AVS_WRITE;
    assign take = req & ~st_q.bus_wait;
    assign wr_lo = AVS_WRITE & take & AVS_BYTEENABLE[0];
    assign rd_buffer = AVS_READ & take &
        (AVS_ADDRESS == `OFS_RECEIVE_BUFFER);

    // Read data are loaded only on a read, so that a write in between
    // leaves the last read value standing for the master
    assign rd_answer = AVS_READ & st_q.bus_wait;

    // Edges seen only on the synchronised line
    assign fall = st_q.rx_prev & ~st_q.rx_sync;
    assign rise = ~st_q.rx_prev & st_q.rx_sync;

    // Port set up for asynchronous use
    assign port_ready = st_q.cfg.port_enable & ~st_q.cfg.clocked_mode;

    // Receiver may start only when fully configured and no overrun stands
    assign rx_enabled = port_ready & st_q.cfg.cont_receive &
        ~st_q.sts.overrun_err & ~st_q.cfg.wake_enable;

    // Eight-bit divisor unless the wide select is on
    assign div_limit = st_q.cfg.wide_divisor ?
        {st_q.cfg.div_high, st_q.cfg.div_low} :
        {8'h00, st_q.cfg.div_low};

    // Slow mode with the eight-bit divisor stretches each sample tick by four
    assign last_pre = (st_q.cfg.high_speed | st_q.cfg.wide_divisor) |
        (st_q.prescale == `SLOW_PRESCALE_LAST);
    assign tick_en = (st_q.divider == div_limit) & last_pre;
    assign mid_bit = tick_en & (st_q.tick == `SAMPLE_POINT);
    assign bit_end = tick_en & (st_q.tick == `OVERSAMPLE_LAST);

    // Character layout depends on frame length
    assign got_byte = st_q.cfg.ninth_enable ? st_q.shifter[7:0] :
        st_q.shifter[8:1];
    assign got_ninth = st_q.cfg.ninth_enable & st_q.shifter[8];
    assign frame_bits = st_q.cfg.ninth_enable ? `BITS_NINE : `BITS_EIGHT;

    // Address filter: only ninth-bit-one characters pass; software
    // clears the detect enable once addressed to hear the data
    assign accept = ~(st_q.cfg.addr_detect & st_q.cfg.ninth_enable) |
        got_ninth;

    // A finished character finds the buffer still unread; a read in
    // the same cycle frees it in time
    assign overrun_hit = st_q.sts.receive_flag & ~rd_buffer;

    // Wake detector edges, used only while armed
    assign wake_fall = st_q.cfg.wake_enable & ~st_q.wake_seen & fall;
    assign wake_rise = st_q.cfg.wake_enable & st_q.wake_seen & rise;

    // Read multiplexer; undecoded offsets and spare bits give zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (AVS_ADDRESS)
            `OFS_PERIPH_FLAGS: begin
                rd_byte[`BIT_RECEIVE_FLAG] = st_q.sts.receive_flag;
            end
            `OFS_BAUD_CONTROL: begin
                // Idle tells software no character is in progress
                rd_byte[`BIT_RECEIVE_IDLE] = (st_q.fsm == RX_IDLE);
                rd_byte[`BIT_WIDE_DIVISOR] = st_q.cfg.wide_divisor;
                rd_byte[`BIT_WAKE_ENABLE] = st_q.cfg.wake_enable;
            end
            `OFS_BAUD_DIV_HIGH: begin
                rd_byte = st_q.cfg.div_high;
            end
            `OFS_BAUD_DIV_LOW: begin
                rd_byte = st_q.cfg.div_low;
            end
            `OFS_RECEIVE_BUFFER: begin
                rd_byte = st_q.sts.rx_buffer;
            end
            `OFS_TRANSMIT_BUFFER: begin
                rd_byte = st_q.cfg.tx_buffer;
            end
            `OFS_TRANSMIT_STATUS: begin
                rd_byte[`BIT_CLOCKED_MODE] = st_q.cfg.clocked_mode;
                rd_byte[`BIT_HIGH_SPEED] = st_q.cfg.high_speed;
                // No transmitter here, so its shifter always reads empty
                rd_byte[`BIT_TX_SHIFT_EMPTY] = 1'b1;
            end
            `OFS_RECEIVE_STATUS: begin
                rd_byte[`BIT_PORT_ENABLE] = st_q.cfg.port_enable;
                rd_byte[`BIT_NINTH_ENABLE] = st_q.cfg.ninth_enable;
                rd_byte[`BIT_CONT_RECEIVE] = st_q.cfg.cont_receive;
                rd_byte[`BIT_ADDR_DETECT] = st_q.cfg.addr_detect;
                rd_byte[`BIT_FRAMING_ERR] = st_q.sts.framing_err;
                rd_byte[`BIT_OVERRUN_ERR] = st_q.sts.overrun_err;
                rd_byte[`BIT_NINTH_DATA] = st_q.sts.ninth_data;
            end
            `OFS_PERIPH_ENABLES: begin
                rd_byte[`BIT_RECEIVE_IE] = st_q.cfg.receive_ie;
            end
            `OFS_INTERRUPT_CONTROL: begin
                rd_byte[`BIT_GLOBAL_IE] = st_q.cfg.global_ie;
                rd_byte[`BIT_PERIPH_IE] = st_q.cfg.periph_ie;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        st_d = st_q;

        // Two-flop synchroniser; first stage feeds only the second
        st_d.rx_meta = RECEIVE_LINE;
        st_d.rx_sync = st_q.rx_meta;
        st_d.rx_prev = st_q.rx_sync;

        // One wait cycle, then the request is answered
        st_d.bus_wait = ~(req & st_q.bus_wait);
        // Writes leave the last read data standing
        if (rd_answer) begin
            st_d.read_data = {24'h000000, rd_byte};
        end

        // Register writes, low byte lane only
        if (wr_lo) begin
            unique case (AVS_ADDRESS)
                `OFS_BAUD_CONTROL: begin
                    st_d.cfg.wide_divisor =
                        AVS_WRITEDATA[`BIT_WIDE_DIVISOR];
                    st_d.cfg.wake_enable =
                        AVS_WRITEDATA[`BIT_WAKE_ENABLE];
                    // Any write rearms the wake detector
                    st_d.wake_seen = 1'b0;
                end
                `OFS_BAUD_DIV_HIGH: begin
                    st_d.cfg.div_high = AVS_WRITEDATA[7:0];
                end
                `OFS_BAUD_DIV_LOW: begin
                    st_d.cfg.div_low = AVS_WRITEDATA[7:0];
                end
                `OFS_TRANSMIT_BUFFER: begin
                    st_d.cfg.tx_buffer = AVS_WRITEDATA[7:0];
                end
                `OFS_TRANSMIT_STATUS: begin
                    st_d.cfg.clocked_mode =
                        AVS_WRITEDATA[`BIT_CLOCKED_MODE];
                    st_d.cfg.high_speed = AVS_WRITEDATA[`BIT_HIGH_SPEED];
                end
                `OFS_RECEIVE_STATUS: begin
                    st_d.cfg.port_enable = AVS_WRITEDATA[`BIT_PORT_ENABLE];
                    st_d.cfg.ninth_enable =
                        AVS_WRITEDATA[`BIT_NINTH_ENABLE];
                    st_d.cfg.cont_receive =
                        AVS_WRITEDATA[`BIT_CONT_RECEIVE];
                    st_d.cfg.addr_detect = AVS_WRITEDATA[`BIT_ADDR_DETECT];
                end
                `OFS_PERIPH_ENABLES: begin
                    st_d.cfg.receive_ie = AVS_WRITEDATA[`BIT_RECEIVE_IE];
                end
                `OFS_INTERRUPT_CONTROL: begin
                    st_d.cfg.global_ie = AVS_WRITEDATA[`BIT_GLOBAL_IE];
                    st_d.cfg.periph_ie = AVS_WRITEDATA[`BIT_PERIPH_IE];
                end
                default: begin
                    // Read-only and unmapped places ignore writes
                end
            endcase
        end

        // Dropping continuous receive clears errors; a character ending
        // in the same cycle still sets its own, since the set wins
        if (~st_d.cfg.cont_receive) begin
            st_d.sts.framing_err = 1'b0;
            st_d.sts.overrun_err = 1'b0;
        end

        // Reading the buffer clears the flag; a new set overrides
        if (rd_buffer) begin
            st_d.sts.receive_flag = 1'b0;
        end

        // Baud generator runs only while a frame is in progress
        if (st_q.fsm != RX_IDLE) begin
            if (st_q.divider == div_limit) begin
                st_d.divider = 16'h0000;
                st_d.prescale = st_q.prescale + 2'h1;
            end else begin
                st_d.divider = st_q.divider + 16'h0001;
            end
            if (tick_en) begin
                st_d.prescale = 2'h0;
                st_d.tick = st_q.tick + 4'h1;
            end
        end

        // Frame sequencer
        unique case (st_q.fsm)
            RX_IDLE: begin
                // Timing restarts from the next start edge itself
                st_d.divider = 16'h0000;
                st_d.shifter = 9'h000;
                st_d.prescale = 2'h0;
                st_d.tick = 4'h0;
                st_d.bit_num = 4'h0;
                if (rx_enabled & fall) begin
                    st_d.fsm = RX_START;
                end
            end
            RX_START: begin
                // A start bit that is high mid-bit was a glitch
                if (mid_bit & st_q.rx_sync) begin
                    st_d.fsm = RX_IDLE;
                end else if (bit_end) begin
                    st_d.fsm = RX_DATA;
                end
            end
            RX_DATA: begin
                // Shift right so the first bit ends up lowest
                if (mid_bit) begin
                    st_d.shifter = {st_q.rx_sync,
                        st_q.shifter[8:1]};
                end
                if (bit_end) begin
                    st_d.bit_num = st_q.bit_num + 4'h1;
                    if (st_q.bit_num + 4'h1 == frame_bits) begin
                        st_d.fsm = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                // Finish at mid stop bit so the next start is not missed
                if (mid_bit) begin
                    st_d.fsm = RX_IDLE;
                    if (accept) begin
                        if (overrun_hit) begin
                            st_d.sts.overrun_err = 1'b1;
                        end else begin
                            st_d.sts.rx_buffer = got_byte;
                            st_d.sts.ninth_data = got_ninth;
                            st_d.sts.framing_err = ~st_q.rx_sync;
                            st_d.sts.receive_flag = 1'b1;
                        end
                    end
                end
            end
        endcase

        // A dropped receive enable abandons the frame in progress
        if (~st_d.cfg.cont_receive) begin
            st_d.fsm = RX_IDLE;
        end

        // Wake-on-break watches line edges with the baud clock stopped
        if (wake_fall) begin
            st_d.sts.receive_flag = 1'b1;
            st_d.wake_seen = 1'b1;
        end

        // Disarm on the rise that ends the break
        if (wake_rise) begin
            st_d.cfg.wake_enable = 1'b0;
            st_d.wake_seen = 1'b0;
        end

        // Interrupt gated by all three enables
        st_d.irq = st_d.sts.receive_flag & st_d.cfg.receive_ie &
            st_d.cfg.global_ie & st_d.cfg.periph_ie;
    end

    // State register; line stages reset high to avoid a false edge
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;
            // Stored bytes and counters start from their reset values
            st_q.read_data <= `RST_READ;
            st_q.divider <= `RST_DIVISOR;
            st_q.cfg.div_high <= `RST_BYTE;
            st_q.cfg.div_low <= `RST_BYTE;
            st_q.cfg.tx_buffer <= `RST_BYTE;
            st_q.sts.rx_buffer <= `RST_BYTE;
            st_q.bus_wait <= 1'b1;
            st_q.rx_meta <= 1'b1;
            st_q.rx_sync <= 1'b1;
            st_q.rx_prev <= 1'b1;
            st_q.fsm <= RX_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign AVS_WAITREQUEST = st_q.bus_wait;
    assign AVS_READDATA = st_q.read_data;
    assign RX_IRQ = st_q.irq;

endmodule
`default_nettype wire

// ---- async_serial_receiver_wake_tb_top.sv ----
// Self-checking bench for the serial receiver with wake-on-break
`timescale 1ns/1ns
`default_nettype none
module async_serial_receiver_wake_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ben = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic line;
    logic irq;
    logic [31:0] got;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] ra [10] = '{8'h0B, 8'h0C, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h8C};
    async_serial_receiver_wake i_dut (
        .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(address),
        .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(ben), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .RECEIVE_LINE(line), .RX_IRQ(irq));
    rx_line_sender i_tx (.CLOCK(clock), .RECEIVE_LINE(line));
    initial forever #2 clock = ~clock;
    // Hang guard; a full run needs well under this
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        wdata <= {24'h0, d};
        rd_req <= !w;
        wr_req <= w;
        do @(posedge clock); while (waitreq !== 1'b0);
        got = rdata;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    // Read and compare the bits under a mask
    task automatic rdc(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, got & {24'h0, m});
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values; idle flag left out of this pass
        foreach (ra[i]) rdc(ra[i], ra[i] == 8'h11 ? 8'hBF : 8'hFF,
            ra[i] == 8'h16 ? 8'h02 : 8'h00);
        wr(8'h12, 8'hFF);
        rdc(8'h12, 8'hFF, 8'hFF);
        wr(8'h15, 8'hFF);
        rdc(8'h15, 8'hFF, 8'hFF);
        wr(8'h14, 8'hFF);
        rdc(8'h14, 8'hFF, 8'h00);
        wr(8'h40, 8'hFF);
        rdc(8'h40, 8'hFF, 8'h00);
        wr(8'h17, 8'hFF);
        rdc(8'h17, 8'hFF, 8'hD8);
        ben <= 4'h0;
        wr(8'h13, 8'hFF);
        ben <= 4'hF;
        rdc(8'h13, 8'hFF, 8'h00);
        // Fast mode, two clocks a tick, 32 clocks a bit
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h01);
        wr(8'h16, 8'h04);
        wr(8'h0B, 8'hC0);
        wr(8'h8C, 8'h20);
        wr(8'h17, 8'h90);
        fork
            i_tx.send(9'h0A5, 8, 1'b1);
            begin
                repeat (100) @(posedge clock);
                rdc(8'h11, 8'h40, 8'h00);
            end
        join
        chk("irq", 32'h1, {31'h0, irq});
        rdc(8'h17, 8'hFF, 8'h90);
        rdc(8'h14, 8'hFF, 8'hA5);
        rdc(8'h0C, 8'h20, 8'h00);
        // Every mix of the three enables with a flag standing
        i_tx.send(9'h096, 8, 1'b1);
        for (int k = 0; k < 8; k++) begin
            wr(8'h0B, {k[1:0], 6'h00});
            wr(8'h8C, {2'h0, k[2], 5'h00});
            repeat (2) @(posedge clock);
            chk("irq", {31'h0, k == 7}, {31'h0, irq});
        end
        rdc(8'h14, 8'hFF, 8'h96);
        // Nine-bit frames, then address filtering on and off
        wr(8'h17, 8'hD0);
        i_tx.send(9'h13C, 9, 1'b1);
        rdc(8'h17, 8'hFF, 8'hD1);
        rdc(8'h14, 8'hFF, 8'h3C);
        wr(8'h17, 8'hD8);
        i_tx.send(9'h011, 9, 1'b1);
        rdc(8'h0C, 8'h20, 8'h00);
        i_tx.send(9'h122, 9, 1'b1);
        rdc(8'h17, 8'hFF, 8'hD9);
        rdc(8'h14, 8'hFF, 8'h22);
        wr(8'h17, 8'hD0);
        i_tx.send(9'h033, 9, 1'b1);
        rdc(8'h14, 8'hFF, 8'h33);
        // Low stop bit, then overrun with the receiver stalled
        wr(8'h17, 8'h90);
        i_tx.send(9'h05A, 8, 1'b0);
        rdc(8'h17, 8'hFF, 8'h94);
        rdc(8'h14, 8'hFF, 8'h5A);
        wr(8'h17, 8'h80);
        rdc(8'h17, 8'hFF, 8'h80);
        wr(8'h17, 8'h90);
        i_tx.send(9'h001, 8, 1'b1);
        i_tx.send(9'h002, 8, 1'b1);
        i_tx.send(9'h003, 8, 1'b1);
        rdc(8'h17, 8'hFF, 8'h92);
        rdc(8'h14, 8'hFF, 8'h01);
        wr(8'h17, 8'h80);
        rdc(8'h17, 8'hFF, 8'h80);
        i_tx.send(9'h055, 8, 1'b1);
        rdc(8'h0C, 8'h20, 8'h00);
        wr(8'h17, 8'h90);
        i_tx.send(9'h044, 8, 1'b1);
        rdc(8'h14, 8'hFF, 8'h44);
        // Clocked mode shuts out asynchronous characters
        wr(8'h16, 8'h14);
        rdc(8'h16, 8'hFF, 8'h16);
        i_tx.send(9'h066, 8, 1'b1);
        rdc(8'h0C, 8'h20, 8'h00);
        // Slow modes: four clocks a tick, 64 clocks a bit
        wr(8'h16, 8'h00);
        wr(8'h13, 8'h00);
        i_tx.bit_clocks = 64;
        i_tx.send(9'h0C3, 8, 1'b1);
        rdc(8'h14, 8'hFF, 8'hC3);
        wr(8'h11, 8'h08);
        wr(8'h13, 8'h03);
        i_tx.send(9'h03C, 8, 1'b1);
        rdc(8'h14, 8'hFF, 8'h3C);
        // Wake on a break, then a zero character
        rdc(8'h11, 8'h40, 8'h40);
        wr(8'h11, 8'h0A);
        rdc(8'h11, 8'h02, 8'h02);
        i_tx.brk(2);
        rdc(8'h0C, 8'h20, 8'h20);
        rdc(8'h11, 8'h02, 8'h00);
        rdc(8'h14, 8'h00, 8'h00);
        rdc(8'h0C, 8'h20, 8'h00);
        i_tx.send(9'h000, 8, 1'b1);
        rdc(8'h17, 8'hFF, 8'h90);
        rdc(8'h14, 8'hFF, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- rx_line_sender.sv ----
// Remote asynchronous sender driving the receive line
`timescale 1ns/1ns
`default_nettype none
module rx_line_sender (
    // Bit timing reference
    input wire logic CLOCK,
    // Line towards the receiver, idle high
    output logic RECEIVE_LINE
);
    // Clocks per bit; set by the bench to match the divisor
    int bit_clocks = 32;
    initial RECEIVE_LINE = 1'b1;
    // One level for whole bit periods
    task automatic hold(input logic v, input int n);
        RECEIVE_LINE <= v;
        repeat (n * bit_clocks) @(posedge CLOCK);
    endtask
    // Start, data least significant first, stop, then idle
    task automatic send(input logic [8:0] d, input int nbits, input logic stop);
        @(posedge CLOCK);
        hold(1'b0, 1);
        for (int i = 0; i < nbits; i++) hold(d[i], 1);
        hold(stop, 1);
        RECEIVE_LINE <= 1'b1;
    endtask
    // Long low level that wakes a sleeping receiver
    task automatic brk(input int n);
        @(posedge CLOCK);
        hold(1'b0, n);
        RECEIVE_LINE <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- rx_wake_checker_asserts.sv ----
// Bus and interrupt port checker for the serial receiver
`timescale 1ns/1ns
`default_nettype none
module rx_wake_checker (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Register bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Serial line and interrupt
    input wire logic RECEIVE_LINE,
    input wire logic RX_IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Places that answer with stored bits
    function automatic logic mapped(input logic [7:0] a);
        return a inside {8'h0B, 8'h0C, [8'h11:8'h17], 8'h8C};
    endfunction
    // Exactly one wait cycle, then back to waiting
    chk_wait_single: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("answer not after one wait cycle");
    chk_answer_cause: assert property (!AVS_WAITREQUEST
        |-> $past(AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)))
        else $error("answer without request");
    // Read data only move on a read answer
    chk_rdata_hold: assert property (!($fell(AVS_WAITREQUEST) && $past(AVS_READ))
        |-> $stable(AVS_READDATA))
        else $error("read data moved outside a read answer");
    chk_upper_zero: assert property (AVS_READDATA[31:8] == 24'h000000)
        else $error("upper read data lanes not zero");
    chk_unmapped_zero: assert property ($fell(AVS_WAITREQUEST) && $past(AVS_READ)
        && !mapped($past(AVS_ADDRESS)) |-> AVS_READDATA == 32'h00000000)
        else $error("unmapped place reads nonzero");
    chk_baud_unused: assert property ($fell(AVS_WAITREQUEST) && $past(AVS_READ)
        && $past(AVS_ADDRESS) == 8'h11 |-> (AVS_READDATA[7:0] & 8'hB5) == 8'h00)
        else $error("unused baud control bits nonzero");
    chk_txstat_bits: assert property ($fell(AVS_WAITREQUEST) && $past(AVS_READ)
        && $past(AVS_ADDRESS) == 8'h16 |-> (AVS_READDATA[7:0] & 8'hEB) == 8'h02)
        else $error("transmit status fixed bits wrong");
    // Buffer read drops the request one edge after the answer
    chk_buffer_clear: assert property ($fell(AVS_WAITREQUEST) && $past(AVS_READ)
        && $past(AVS_ADDRESS) == 8'h14 |=> !RX_IRQ)
        else $error("interrupt stands after buffer read");
    chk_irq_fall: assert property ($fell(RX_IRQ)
        |-> $past(!AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)))
        else $error("interrupt fell without bus access");
    cov_read: cover property ($fell(AVS_WAITREQUEST) && $past(AVS_READ));
    cov_write: cover property ($fell(AVS_WAITREQUEST) && $past(AVS_WRITE));
    cov_irq: cover property ($rose(RX_IRQ));
endmodule
bind async_serial_receiver_wake rx_wake_checker i_chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .RECEIVE_LINE(RECEIVE_LINE), .RX_IRQ(RX_IRQ));
`default_nettype wire
